// file: logic/srss_pkg.sv
// shared constants for the servo run/stop sequencer
package srss_pkg;
  // register byte offsets
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_MODE = 8'h04;
  localparam logic [7:0] OFS_FUNC = 8'h08;
  localparam logic [7:0] OFS_SPD1 = 8'h0c;
  localparam logic [7:0] OFS_SPD2 = 8'h10;
  localparam logic [7:0] OFS_SPD3 = 8'h14;
  localparam logic [7:0] OFS_SPD4 = 8'h18;
  localparam logic [7:0] OFS_SPD5 = 8'h1c;
  localparam logic [7:0] OFS_SPD6 = 8'h20;
  localparam logic [7:0] OFS_SPD7 = 8'h24;
  localparam logic [7:0] OFS_ACC = 8'h28;
  localparam logic [7:0] OFS_DEC = 8'h2c;
  localparam logic [7:0] OFS_TQC = 8'h30;
  localparam logic [7:0] OFS_TLIM = 8'h34;
  localparam logic [7:0] OFS_STAT = 8'h38;
  localparam logic [7:0] OFS_ACT = 8'h3c;
  localparam logic [7:0] OFS_SPDOUT = 8'h40;
  // reset values
  localparam logic [15:0] RST_MODE = 16'h0002;
  localparam logic [15:0] RST_FUNC = 16'h0002;
  localparam logic [15:0] RST_SPD1 = 16'h0064;
  localparam logic [15:0] RST_SPD2 = 16'h01f4;
  localparam logic [15:0] RST_SPD3 = 16'h03e8;
  localparam logic [15:0] RST_TLIM = 16'h0064;
  // field codes
  localparam logic [3:0] MODE_TORQUE = 4'h2;
  localparam logic [7:0] FUNC_BRAKE_ON = 8'h12;
  localparam logic [7:0] FUNC_BRAKE_OFF = 8'h02;
  localparam logic [15:0] PCT_FULL = 16'h0064;
  // bit positions
  localparam int CTRL_POWER_CYCLE = 0;
  localparam int CTRL_ALARM = 1;
  localparam int CTRL_ALARM_CLR = 2;
  // timing, 100 MHz clock
  localparam int CLK_MHZ = 100;
  localparam int DISP_MS = 2000;
  localparam int DISP_CYC = DISP_MS * CLK_MHZ * 1000;
  localparam int FILT_NS = 3555000;
  localparam int FILT_CYC = (FILT_NS * CLK_MHZ + 999) / 1000;
  localparam int MS_CYC = CLK_MHZ * 1000;
  typedef enum logic [2:0] {
    ST_OFF = 3'b000,
    ST_RUN = 3'b001,
    ST_DECEL = 3'b010,
    ST_SUDDEN = 3'b011,
    ST_DBRAKE = 3'b100,
    ST_COAST = 3'b101
  } srss_state_t;
endpackage : srss_pkg

// file: logic/srss_sequencer.sv
// servo run/stop sequencer with wishbone register slave
// Notes on behaviour
// - after power-up show mode indicator, then data two seconds later.
// - control mode from parameter 0, valid only after a power cycle.
// - parameters 0 and 1 latched into active set only at power cycle.
// - servo-on after power-up in speed mode enters ready, base on, motor locked.
// - speed mode: forward start runs CCW, reverse start CW, selected speed.
// - torque mode: forward select torque CCW, reverse select torque CW.
// - servo-on off shuts base circuit, no dynamic brake, motor coasts.
// - any alarm shuts base and engages dynamic brake, sudden stop.
// - emergency stop off: base off, dynamic brake, emergency alarm raised.
// - speed mode stroke end off: sudden stop, servo lock, reverse allowed.
// - speed mode both starts equal: decelerate with deceleration constant.
// - torque mode both selects equal: motor coasts.
// - sudden stop is a ramp with deceleration constant zero.
// - speeds 1 to 3 held in parameters 8 to 10, chosen by selects.
// - torque command smoothed by parameter 14 time constant.
// - parameter 28 caps output torque percentage.
// - function value 12 enables brake interlock, 02 disables it.
// - discrete inputs filtered, default 3.555 ms.
// - torque mode selects pick analog limit or internal limits 1 to 7.
`timescale 1ns/10ps
`default_nettype none
module srss_sequencer #(
  parameter int DISP_CYCLES = srss_pkg::DISP_CYC,
  parameter int FILT_CYCLES = srss_pkg::FILT_CYC,
  parameter int MS_CYCLES = srss_pkg::MS_CYC,
  parameter int NUM_IN = 10
) (
  // clock and reset
  input wire logic i_clock,
  input wire logic i_sys_rst,
  // wishbone slave
  input wire logic i_wb_cyc,
  input wire logic i_wb_stb,
  input wire logic i_wb_we,
  input wire logic [7:0] i_wb_adr,
  input wire logic [3:0] i_wb_sel,
  input wire logic [31:0] i_wb_dat,
  output logic [31:0] o_wb_dat,
  output logic o_wb_ack,
  // discrete contacts from host
  input wire logic i_servo_on_in,
  input wire logic i_emergency_stop_in,
  input wire logic i_fwd_stroke_end_in,
  input wire logic i_rev_stroke_end_in,
  input wire logic i_fwd_start_in,
  input wire logic i_rev_start_in,
  input wire logic i_speed_sel0_in,
  input wire logic i_speed_sel1_in,
  input wire logic i_speed_sel2_in,
  input wire logic i_alarm_in,
  // analog limit and torque command, sampled words
  input wire logic [15:0] i_analog_speed_limit_in,
  input wire logic [15:0] i_torque_cmd_in,
  // drive outputs
  output logic o_base_on,
  output logic o_dyn_brake,
  output logic o_dir_ccw,
  output logic o_dir_cw,
  output logic [15:0] o_speed_ref,
  output logic [15:0] o_torque_ref,
  output logic [15:0] o_torque_cap,
  output logic o_brake_interlock_out,
  output logic o_emergency_stop_alarm,
  output logic o_show_data,
  output logic o_torque_mode
);
  // ---------------------------------------------------------------
  // input synchronisers and filter
  // ---------------------------------------------------------------
  logic [NUM_IN-1:0] raw_in;
  logic [NUM_IN-1:0] sync1_ff;
  logic [NUM_IN-1:0] sync2_ff;
  logic [NUM_IN-1:0] filt_ff;
  // estop contact resets released: reset alone must not latch the alarm
  localparam logic [NUM_IN-1:0] IN_RST = {{(NUM_IN-2){1'b0}}, 2'b10};
  assign raw_in = {i_alarm_in, i_speed_sel2_in, i_speed_sel1_in,
                   i_speed_sel0_in, i_rev_start_in, i_fwd_start_in,
                   i_rev_stroke_end_in, i_fwd_stroke_end_in,
                   i_emergency_stop_in, i_servo_on_in};
  always_ff @(posedge i_clock) begin
    if (i_sys_rst) begin
      sync1_ff <= IN_RST;
      sync2_ff <= IN_RST;
    end else begin
      sync1_ff <= raw_in;
      sync2_ff <= sync1_ff;
    end
  end
  // per-input stability counter; debounce trades latency for noise margin
  genvar gi;
  generate
    for (gi = 0; gi < NUM_IN; gi++) begin : g_filt
      logic [31:0] cnt_ff;
      always_ff @(posedge i_clock) begin
        if (i_sys_rst) begin
          cnt_ff <= '0;
          filt_ff[gi] <= IN_RST[gi];
        end else if (sync2_ff[gi] == filt_ff[gi]) begin
          cnt_ff <= '0;
        end else if (cnt_ff >= 32'(FILT_CYCLES - 1)) begin
          cnt_ff <= '0;
          filt_ff[gi] <= sync2_ff[gi];
        end else begin
          cnt_ff <= cnt_ff + 32'h1;
        end
      end
    end
  endgenerate
  logic servo_on, estop_ok, fwd_travel_ok, rev_travel_ok, st_f, st_r, alarm;
  logic [2:0] spsel;
  assign servo_on = filt_ff[0];
  assign estop_ok = filt_ff[1];
  assign fwd_travel_ok = filt_ff[2];
  assign rev_travel_ok = filt_ff[3];
  assign st_f = filt_ff[4];
  assign st_r = filt_ff[5];
  assign spsel = filt_ff[8:6];
  assign alarm = filt_ff[9];
  // ---------------------------------------------------------------
  // registers
  // ---------------------------------------------------------------
  logic [15:0] mode_ff, func_ff, act_mode_ff, act_func_ff;
  logic [15:0] spd_ff [7];
  logic [15:0] acc_ff, dec_ff, tqc_ff, tlim_ff;
  logic estop_alarm_ff;
  logic wr, rd_req, hit;
  logic pcycle_wr, aclr_wr;
  assign wr = i_wb_cyc & i_wb_stb & i_wb_we & ~o_wb_ack;
  assign pcycle_wr = wr && i_wb_adr == srss_pkg::OFS_CTRL &&
                     i_wb_sel[0] && i_wb_dat[srss_pkg::CTRL_POWER_CYCLE];
  assign aclr_wr = wr && i_wb_adr == srss_pkg::OFS_CTRL &&
                   i_wb_sel[0] && i_wb_dat[srss_pkg::CTRL_ALARM_CLR];
  function automatic logic [15:0] merge(input logic [15:0] old);
    merge = {i_wb_sel[1] ? i_wb_dat[15:8] : old[15:8],
             i_wb_sel[0] ? i_wb_dat[7:0] : old[7:0]};
  endfunction
  always_ff @(posedge i_clock) begin
    if (i_sys_rst) begin
      mode_ff <= srss_pkg::RST_MODE;
      func_ff <= srss_pkg::RST_FUNC;
      spd_ff[0] <= srss_pkg::RST_SPD1;
      spd_ff[1] <= srss_pkg::RST_SPD2;
      spd_ff[2] <= srss_pkg::RST_SPD3;
      for (int k = 3; k < 7; k++) begin
        spd_ff[k] <= '0;
      end
      acc_ff <= '0;
      dec_ff <= '0;
      tqc_ff <= '0;
      tlim_ff <= srss_pkg::RST_TLIM;
    end else if (wr) begin
      if (i_wb_adr == srss_pkg::OFS_MODE) begin
        mode_ff <= merge(mode_ff);
      end else if (i_wb_adr == srss_pkg::OFS_FUNC) begin
        func_ff <= merge(func_ff);
      end else if (i_wb_adr == srss_pkg::OFS_SPD1) begin
        spd_ff[0] <= merge(spd_ff[0]);
      end else if (i_wb_adr == srss_pkg::OFS_SPD2) begin
        spd_ff[1] <= merge(spd_ff[1]);
      end else if (i_wb_adr == srss_pkg::OFS_SPD3) begin
        spd_ff[2] <= merge(spd_ff[2]);
      end else if (i_wb_adr == srss_pkg::OFS_SPD4) begin
        spd_ff[3] <= merge(spd_ff[3]);
      end else if (i_wb_adr == srss_pkg::OFS_SPD5) begin
        spd_ff[4] <= merge(spd_ff[4]);
      end else if (i_wb_adr == srss_pkg::OFS_SPD6) begin
        spd_ff[5] <= merge(spd_ff[5]);
      end else if (i_wb_adr == srss_pkg::OFS_SPD7) begin
        spd_ff[6] <= merge(spd_ff[6]);
      end else if (i_wb_adr == srss_pkg::OFS_ACC) begin
        acc_ff <= merge(acc_ff);
      end else if (i_wb_adr == srss_pkg::OFS_DEC) begin
        dec_ff <= merge(dec_ff);
      end else if (i_wb_adr == srss_pkg::OFS_TQC) begin
        tqc_ff <= merge(tqc_ff);
      end else if (i_wb_adr == srss_pkg::OFS_TLIM) begin
        tlim_ff <= merge(tlim_ff);
      end
    end
  end
  // active set: loaded only at reset or a simulated power cycle
  always_ff @(posedge i_clock) begin
    if (i_sys_rst) begin
      act_mode_ff <= srss_pkg::RST_MODE;
      act_func_ff <= srss_pkg::RST_FUNC;
    end else if (pcycle_wr) begin
      act_mode_ff <= mode_ff;
      act_func_ff <= func_ff;
    end
  end
  logic tmode;
  assign tmode = act_mode_ff[7:4] == srss_pkg::MODE_TORQUE;
  // read side and ack
  logic [31:0] rdata;
  always_comb begin
    rdata = '0;
    if (i_wb_adr == srss_pkg::OFS_MODE) begin
      rdata = {16'h0, mode_ff};
    end else if (i_wb_adr == srss_pkg::OFS_FUNC) begin
      rdata = {16'h0, func_ff};
    end else if (i_wb_adr == srss_pkg::OFS_SPD1) begin
      rdata = {16'h0, spd_ff[0]};
    end else if (i_wb_adr == srss_pkg::OFS_SPD2) begin
      rdata = {16'h0, spd_ff[1]};
    end else if (i_wb_adr == srss_pkg::OFS_SPD3) begin
      rdata = {16'h0, spd_ff[2]};
    end else if (i_wb_adr == srss_pkg::OFS_SPD4) begin
      rdata = {16'h0, spd_ff[3]};
    end else if (i_wb_adr == srss_pkg::OFS_SPD5) begin
      rdata = {16'h0, spd_ff[4]};
    end else if (i_wb_adr == srss_pkg::OFS_SPD6) begin
      rdata = {16'h0, spd_ff[5]};
    end else if (i_wb_adr == srss_pkg::OFS_SPD7) begin
      rdata = {16'h0, spd_ff[6]};
    end else if (i_wb_adr == srss_pkg::OFS_ACC) begin
      rdata = {16'h0, acc_ff};
    end else if (i_wb_adr == srss_pkg::OFS_DEC) begin
      rdata = {16'h0, dec_ff};
    end else if (i_wb_adr == srss_pkg::OFS_TQC) begin
      rdata = {16'h0, tqc_ff};
    end else if (i_wb_adr == srss_pkg::OFS_TLIM) begin
      rdata = {16'h0, tlim_ff};
    end else if (i_wb_adr == srss_pkg::OFS_STAT) begin
      rdata = {16'h0, 5'h0, o_show_data, o_emergency_stop_alarm,
               o_dyn_brake, o_base_on, o_dir_ccw, o_dir_cw,
               o_brake_interlock_out, 1'b0, o_torque_mode, 2'h0};
    end else if (i_wb_adr == srss_pkg::OFS_ACT) begin
      rdata = {act_func_ff, act_mode_ff};
    end else if (i_wb_adr == srss_pkg::OFS_SPDOUT) begin
      rdata = {o_torque_ref, o_speed_ref};
    end
  end
  assign rd_req = i_wb_cyc & i_wb_stb & ~o_wb_ack;
  assign hit = 1'b1; // unmapped reads return zero, writes dropped
  always_ff @(posedge i_clock) begin
    if (i_sys_rst) begin
      o_wb_ack <= 1'b0;
      o_wb_dat <= '0;
    end else begin
      o_wb_ack <= rd_req & hit;
      o_wb_dat <= rdata;
    end
  end
  // ---------------------------------------------------------------
  // power-up display timer
  // ---------------------------------------------------------------
  logic [31:0] disp_cnt_ff;
  always_ff @(posedge i_clock) begin
    if (i_sys_rst || pcycle_wr) begin
      disp_cnt_ff <= '0;
      o_show_data <= 1'b0;
    end else if (disp_cnt_ff >= 32'(DISP_CYCLES - 1)) begin
      o_show_data <= 1'b1;
    end else begin
      disp_cnt_ff <= disp_cnt_ff + 32'h1;
    end
  end
  assign o_torque_mode = tmode; // indicator shown while o_show_data low
  // ---------------------------------------------------------------
  // emergency stop alarm (sticky until cleared with input restored)
  // ---------------------------------------------------------------
  always_ff @(posedge i_clock) begin
    if (i_sys_rst) begin
      estop_alarm_ff <= 1'b0;
    end else if (!estop_ok) begin
      estop_alarm_ff <= 1'b1;
    end else if (aclr_wr) begin
      estop_alarm_ff <= 1'b0;
    end
  end
  assign o_emergency_stop_alarm = estop_alarm_ff;
  // ---------------------------------------------------------------
  // run/stop state machine
  // ---------------------------------------------------------------
  srss_pkg::srss_state_t state_ff, nxt_state;
  logic run_f, run_r, stroke_blk;
  // speed mode start pair or torque mode select pair share pins
  assign run_f = st_f & ~st_r;
  assign run_r = st_r & ~st_f;
  // stroke end only blocks travel toward that end
  assign stroke_blk = !tmode && ((run_f && !fwd_travel_ok) ||
                                 (run_r && !rev_travel_ok));
  logic [15:0] speed_ff;
  always_comb begin
    nxt_state = state_ff;
    if (alarm || estop_alarm_ff) begin
      nxt_state = srss_pkg::ST_DBRAKE;
    end else if (!servo_on) begin
      nxt_state = srss_pkg::ST_OFF;
    end else begin
      case (state_ff)
        srss_pkg::ST_DBRAKE: nxt_state = srss_pkg::ST_OFF;
        default: begin
          if (stroke_blk) begin
            nxt_state = srss_pkg::ST_SUDDEN;
          end else if (run_f || run_r) begin
            nxt_state = srss_pkg::ST_RUN;
          end else if (tmode) begin
            nxt_state = srss_pkg::ST_COAST;
          end else begin
            nxt_state = srss_pkg::ST_DECEL;
          end
        end
      endcase
    end
  end
  always_ff @(posedge i_clock) begin
    if (i_sys_rst) begin
      state_ff <= srss_pkg::ST_OFF;
    end else begin
      state_ff <= nxt_state;
    end
  end
  // base on whenever servo-on and no brake/coast; stop states hold lock
  always_ff @(posedge i_clock) begin
    if (i_sys_rst) begin
      o_base_on <= 1'b0;
      o_dyn_brake <= 1'b0;
      o_dir_ccw <= 1'b0;
      o_dir_cw <= 1'b0;
    end else begin
      o_base_on <= nxt_state == srss_pkg::ST_RUN ||
                   nxt_state == srss_pkg::ST_DECEL ||
                   nxt_state == srss_pkg::ST_SUDDEN;
      o_dyn_brake <= nxt_state == srss_pkg::ST_DBRAKE;
      o_dir_ccw <= nxt_state == srss_pkg::ST_RUN && run_f;
      o_dir_cw <= nxt_state == srss_pkg::ST_RUN && run_r;
    end
  end
  // ---------------------------------------------------------------
  // speed target and ramp
  // ---------------------------------------------------------------
  logic [15:0] target;
  always_comb begin
    if (spsel == 3'h0) begin
      target = tmode ? i_analog_speed_limit_in : '0;
    end else begin
      target = spd_ff[spsel - 3'h1];
    end
  end
  // one rpm step per (const ms * ms cycles / target); simplified to
  // one step per ms-scaled tick of time constant per 1000 rpm
  logic [31:0] tick_ff;
  logic [15:0] tconst, goal;
  logic step;
  assign goal = (state_ff == srss_pkg::ST_RUN) ? target : '0;
  assign tconst = (goal > speed_ff) ? acc_ff :
                  (state_ff == srss_pkg::ST_SUDDEN) ? '0 : dec_ff;
  assign step = tconst == '0 || tick_ff >= 32'(tconst) * 32'(MS_CYCLES / 1000);
  always_ff @(posedge i_clock) begin
    if (i_sys_rst || step) begin
      tick_ff <= '0;
    end else begin
      tick_ff <= tick_ff + 32'h1;
    end
  end
  always_ff @(posedge i_clock) begin
    if (i_sys_rst || !o_base_on) begin
      speed_ff <= '0;
    end else if (tconst == '0) begin
      speed_ff <= goal; // zero constant jumps at once
    end else if (step && speed_ff < goal) begin
      speed_ff <= speed_ff + 16'h1;
    end else if (step && speed_ff > goal) begin
      speed_ff <= speed_ff - 16'h1;
    end
  end
  assign o_speed_ref = speed_ff;
  // ---------------------------------------------------------------
  // torque smoothing and cap
  // ---------------------------------------------------------------
  logic [15:0] tq_ff;
  logic [31:0] tq_tick_ff;
  logic tq_step;
  assign tq_step = tqc_ff == '0 ||
                   tq_tick_ff >= 32'(tqc_ff) * 32'(MS_CYCLES / 1000);
  always_ff @(posedge i_clock) begin
    if (i_sys_rst || tq_step) begin
      tq_tick_ff <= '0;
    end else begin
      tq_tick_ff <= tq_tick_ff + 32'h1;
    end
  end
  always_ff @(posedge i_clock) begin
    if (i_sys_rst || !o_base_on) begin
      tq_ff <= '0;
    end else if (tqc_ff == '0) begin
      tq_ff <= i_torque_cmd_in;
    end else if (tq_step && tq_ff < i_torque_cmd_in) begin
      tq_ff <= tq_ff + 16'h1;
    end else if (tq_step && tq_ff > i_torque_cmd_in) begin
      tq_ff <= tq_ff - 16'h1;
    end
  end
  assign o_torque_cap = tlim_ff;
  assign o_torque_ref = (tq_ff > tlim_ff) ? tlim_ff : tq_ff;
  assign o_brake_interlock_out =
    (act_func_ff[7:0] == srss_pkg::FUNC_BRAKE_ON) && o_base_on;
  // ---------------------------------------------------------------
  // assertions
  // ---------------------------------------------------------------
  property p_dbrake_base;
    @(posedge i_clock) disable iff (i_sys_rst)
      o_dyn_brake |-> !o_base_on;
  endproperty
  a_dbrake_base: assert property (p_dbrake_base)
    else $error("brake with base on");
  property p_alarm;
    @(posedge i_clock) disable iff (i_sys_rst)
      alarm |=> o_dyn_brake;
  endproperty
  a_alarm: assert property (p_alarm)
    else $error("alarm without brake");
  property p_coast;
    @(posedge i_clock) disable iff (i_sys_rst)
      (!servo_on && !alarm && !estop_alarm_ff)
      |=> (!o_base_on && !o_dyn_brake);
  endproperty
  a_coast: assert property (p_coast)
    else $error("servo off not coasting");
  property p_estop;
    @(posedge i_clock) disable iff (i_sys_rst)
      !estop_ok |=> o_emergency_stop_alarm ##1 o_dyn_brake;
  endproperty
  a_estop: assert property (p_estop)
    else $error("emergency stop not handled");
  property p_latch;
    @(posedge i_clock) disable iff (i_sys_rst)
      !pcycle_wr |=> $stable(act_mode_ff) && $stable(act_func_ff);
  endproperty
  a_latch: assert property (p_latch)
    else $error("active config changed without power cycle");
  property p_cap;
    @(posedge i_clock) disable iff (i_sys_rst)
      o_torque_ref <= tlim_ff;
  endproperty
  a_cap: assert property (p_cap)
    else $error("torque above cap");
  property p_dirs;
    @(posedge i_clock) disable iff (i_sys_rst)
      !(o_dir_ccw && o_dir_cw);
  endproperty
  a_dirs: assert property (p_dirs)
    else $error("both directions");
  property p_tcoast;
    @(posedge i_clock) disable iff (i_sys_rst)
      (tmode && servo_on && !alarm && !estop_alarm_ff && st_f == st_r)
      |=> !o_base_on;
  endproperty
  a_tcoast: assert property (p_tcoast)
    else $error("torque mode not coasting");
  c_run: cover property (@(posedge i_clock) o_dir_ccw);
  c_decel: cover property (@(posedge i_clock)
    state_ff == srss_pkg::ST_DECEL && speed_ff != '0);
  c_estop: cover property (@(posedge i_clock) o_emergency_stop_alarm);
endmodule : srss_sequencer
`default_nettype wire

// file: tb/srss_host_model.sv
// host controller model driving the discrete contacts
`timescale 1ns/10ps
`default_nettype none
module srss_host_model (
  // clock
  input wire logic i_clock,
  // contact levels wanted by the bench
  input wire logic [9:0] i_want,
  // contacts toward the sequencer
  output logic [9:0] o_contacts
);
  // relay bank: levels move only just after an edge, never mid-cycle
  initial o_contacts = 10'h000;
  always @(posedge i_clock) begin
    o_contacts <= i_want;
  end
endmodule // srss_host_model
`default_nettype wire

// file: tb/tb_srss_sequencer.sv
// self-checking bench for the run/stop sequencer
`timescale 1ns/10ps
`default_nettype none
module tb_srss_sequencer;
  // contacts: servo, estop, fstroke, rstroke, fst, rst, sel[2:0], alarm
  localparam logic [9:0] OK = 10'h00f;
  logic clk, rst, cyc, stb, we, ack, base, brk, ccw, cw, bil, emga, show;
  logic tmode;
  logic [7:0] adr;
  logic [3:0] sel;
  logic [31:0] wdat, rd, rdat;
  logic [15:0] spd, tcap, ana, tcmd, tref, tq_exp;
  logic [9:0] want, ct;
  int mismatches, num_checks, k;
  int sp[4];
  srss_host_model srss_host_model_inst (.i_clock(clk), .i_want(want),
    .o_contacts(ct));
  srss_sequencer #(.DISP_CYCLES(20), .FILT_CYCLES(3), .MS_CYCLES(1000))
    srss_sequencer_inst (.i_clock(clk), .i_sys_rst(rst), .i_wb_cyc(cyc),
    .i_wb_stb(stb), .i_wb_we(we), .i_wb_adr(adr), .i_wb_sel(sel),
    .i_wb_dat(wdat), .o_wb_dat(rdat), .o_wb_ack(ack),
    .i_servo_on_in(ct[0]), .i_emergency_stop_in(ct[1]),
    .i_fwd_stroke_end_in(ct[2]), .i_rev_stroke_end_in(ct[3]),
    .i_fwd_start_in(ct[4]), .i_rev_start_in(ct[5]),
    .i_speed_sel0_in(ct[6]), .i_speed_sel1_in(ct[7]),
    .i_speed_sel2_in(ct[8]), .i_alarm_in(ct[9]),
    .i_analog_speed_limit_in(ana), .i_torque_cmd_in(tcmd),
    .o_base_on(base), .o_dyn_brake(brk), .o_dir_ccw(ccw), .o_dir_cw(cw),
    .o_speed_ref(spd), .o_torque_ref(tref), .o_torque_cap(tcap),
    .o_brake_interlock_out(bil), .o_emergency_stop_alarm(emga),
    .o_show_data(show), .o_torque_mode(tmode));
  // ------------------------------------------------------------
  // helpers
  // ------------------------------------------------------------
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  task automatic test_done();
    $display("checks %0d mismatches %0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] e,
                     input logic [31:0] g);
    num_checks++;
    if (g !== e) begin
      mismatches++;
      $display("unexpected %s expected %h seen %h", nm, e, g);
    end
  endtask
  // classic single cycle; the answer time is the slave's business
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int i;
    @(posedge clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    for (i = 0; i < 50; i++) begin
      @(posedge clk);
      if (ack === 1'b1) break;
    end
    rd = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
    if (i == 50) begin
      mismatches++;
      test_done();
    end
  endtask
  // filter plus sync takes a fixed handful of edges
  task automatic put(input logic [9:0] c);
    want <= c;
    repeat (10) @(posedge clk);
  endtask
  task automatic wait_spd(input int e);
    int i;
    for (i = 0; i < 4000 && spd !== 16'(e); i++) @(posedge clk);
    chk("speed", 32'(e), {16'h0000, spd});
    if (spd !== 16'(e)) test_done();
  endtask
  // ------------------------------------------------------------
  // main sequence
  // ------------------------------------------------------------
  initial begin
    {cyc, stb, we, adr, wdat, want} = '0;
    sel = 4'h3;
    mismatches = 0;
    num_checks = 0;
    void'($urandom(87));
    // limit kept small so the ramp to it fits inside the wait bound
    ana = 16'($urandom % 300);
    tcmd = 16'($urandom);
    sp[0] = 0;
    for (k = 1; k < 4; k++) sp[k] = 8 + $urandom % 200;
    rst = 1'b1;
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    #1 chk("show", 0, show);
    wb(1'b1, 8'h44, 32'h0000_ffff);
    wb(1'b0, 8'h44, 0);
    chk("unmapped", 0, rd);
    wb(1'b0, srss_pkg::OFS_MODE, 0);
    chk("mode", {16'h0, srss_pkg::RST_MODE}, rd);
    wb(1'b0, srss_pkg::OFS_FUNC, 0);
    chk("func", {16'h0, srss_pkg::RST_FUNC}, rd);
    wb(1'b0, srss_pkg::OFS_SPD3, 0);
    chk("spd3", {16'h0, srss_pkg::RST_SPD3}, rd);
    wb(1'b0, srss_pkg::OFS_TLIM, 0);
    chk("tlim", {16'h0, srss_pkg::RST_TLIM}, rd);
    repeat (6) @(posedge clk);
    chk("show", 1, show);
    $display("test reset done");
    for (k = 1; k < 4; k++) begin
      wb(1'b1, srss_pkg::OFS_SPD1 + 8'(4 * (k - 1)), sp[k]);
    end
    wb(1'b1, srss_pkg::OFS_ACC, 1);
    wb(1'b1, srss_pkg::OFS_DEC, 5);
    put(OK);
    chk("estop at start", 1, emga);
    wb(1'b1, srss_pkg::OFS_CTRL, 32'h4);
    repeat (2) @(posedge clk);
    chk("base", 1, base);
    chk("brake", 0, brk);
    for (k = 1; k < 4; k++) begin
      put(OK | 10'h010 | 10'(k << 6));
      wait_spd(sp[k]);
      chk("ccw", 1, ccw);
    end
    put(OK | 10'h070);
    chk("ramping", 1, spd != 16'h0000);
    wait_spd(0);
    put(OK | 10'h060);
    wait_spd(sp[1]);
    chk("cw", 1, cw);
    put(10'h067);
    chk("stroke stop", 0, spd);
    chk("base", 1, base);
    put(10'h057);
    wait_spd(sp[1]);
    put(OK & 10'h05e);
    chk("coast", 2'b00, {base, brk});
    $display("test speed mode done");
    put(OK | 10'h050);
    put(OK | 10'h250);
    chk("alarm", 2'b01, {base, brk});
    put(OK);
    put(OK | 10'h050);
    put(10'h05d);
    chk("estop", 3'b011, {base, brk, emga});
    put(OK);
    wb(1'b1, srss_pkg::OFS_CTRL, 32'h4);
    @(posedge clk);
    #1 chk("estop clr", 0, emga);
    $display("test stops done");
    wb(1'b1, srss_pkg::OFS_MODE, 32'h20);
    wb(1'b1, srss_pkg::OFS_FUNC, {24'h0, srss_pkg::FUNC_BRAKE_ON});
    wb(1'b1, srss_pkg::OFS_TLIM, 50);
    chk("mode held", 0, tmode);
    wb(1'b1, srss_pkg::OFS_CTRL, 32'h1);
    @(posedge clk);
    #1 chk("mode", 1, tmode);
    chk("cap", 50, tcap);
    put(OK | 10'h010);
    chk("tq ccw", 2'b10, {ccw, cw});
    chk("interlock", 1, bil);
    // zero smoothing constant: command passes, capped at 50 percent
    tq_exp = (tcmd > 16'h0032) ? 16'h0032 : tcmd;
    chk("torque ref", {16'h0, tq_exp}, {16'h0, tref});
    wait_spd(ana);
    put(OK | 10'h020);
    chk("tq cw", 2'b01, {ccw, cw});
    put(OK | 10'h030);
    chk("tq coast", 3'b000, {ccw, cw, brk});
    wb(1'b1, srss_pkg::OFS_FUNC, {24'h0, srss_pkg::FUNC_BRAKE_OFF});
    wb(1'b1, srss_pkg::OFS_CTRL, 32'h1);
    put(OK | 10'h010);
    chk("interlock", 0, bil);
    $display("test torque mode done");
    test_done();
  end
endmodule // tb_srss_sequencer
`default_nettype wire
